// >>> design/rpu_pkg.sv
// package of constants for the region protection unit
package rpu_pkg;
    localparam int          NUM_REGIONS    = 8;
    localparam logic [7:0]  REGION_COUNT   = 8'h08;
    localparam logic [31:0] ADDR_TYPE      = 32'he000ed90;
    localparam logic [31:0] ADDR_CTRL      = 32'he000ed94;
    localparam logic [31:0] ADDR_RNR       = 32'he000ed98;
    localparam logic [31:0] ADDR_BASE      = 32'he000ed9c;
    localparam logic [31:0] ADDR_ATTR      = 32'he000eda0;
    localparam logic [31:0] ADDR_BASE_A1   = 32'he000eda4;
    localparam logic [31:0] ADDR_ATTR_A1   = 32'he000eda8;
    localparam logic [31:0] ADDR_BASE_A2   = 32'he000edac;
    localparam logic [31:0] ADDR_ATTR_A2   = 32'he000edb0;
    localparam logic [31:0] ADDR_BASE_A3   = 32'he000edb4;
    localparam logic [31:0] ADDR_ATTR_A3   = 32'he000edb8;
    localparam logic [31:0] ADDR_END       = 32'he000edef;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_HFNMI_BIT = 1;
    localparam int          CTRL_PRIV_BIT  = 2;
    localparam logic [2:0]  CTRL_MASK      = 3'h7;
    localparam int          BASE_VALID_BIT = 4;
    localparam logic [31:0] BASE_ADDR_MASK = 32'hffffffe0;
    localparam int          TYPE_DREG_LSB  = 8;
    localparam logic [8:0]  EXC_NMI        = 9'h002;
    localparam logic [8:0]  EXC_HARD_FAULT_EXCEPTION  = 9'h003;
    localparam int          ATTR_EN_BIT    = 0;
    localparam int          ATTR_SRD_LSB   = 8;
    localparam logic [5:0]  SIZE_FULL      = 6'h20;
    localparam logic [5:0]  SIZE_SUBREG    = 6'h08;
    localparam logic [2:0]  AP_BACKGROUND  = 3'h1;
    localparam logic [3:0]  XN_TOP_LIMIT   = 4'h9;
    localparam logic [2:0]  XN_PERIPH_SEG  = 3'h2;
    localparam logic [4:0]  DEFAULT_TYPE   = 5'h00;
    localparam logic [31:0] RESET_CTRL     = 32'h00000000;
endpackage : rpu_pkg

// >>> design/rpu_top.sv
// region protection unit: access checking and its register file
// What this block does
// - vector reads and peripheral bus bypass checks
// - fault-level handlers use default map unless enabled
// - global enable clear gives default attributes
// - scan all regions, highest hit wins
// - enabled bit; size exponent is field plus one
// - match full space or upper address bits
// - large regions use eight sub-region disables
// - winning region supplies type, share, permission, xn
// - miss without background map faults, flags set
// - background map: permission 001, xn by address
// - check permissions against write, privilege, fetch
// - violations raise memory-management exception
// - byte, halfword, word register access, little endian
// - unprivileged register access faults, ignored
// - absent unit: every register, type included, reads zero; writes ignored
// - base and attribute reach selected region
// - alias pairs reach selected region plus 1..3
// - type bits 15:8 give region count
// - instruction count and split flag read zero
// - background bit ignored while disabled
// - valid base write loads region number
`timescale 1ns/1ps
`default_nettype none

module rpu_top #(
    parameter bit PRESENT = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic        acc_valid_i,
    input  wire logic [31:0] acc_addr_i,
    input  wire logic        acc_write_i,
    input  wire logic        acc_priv_i,
    input  wire logic        acc_fetch_i,
    input  wire logic        acc_vector_i,
    input  wire logic [8:0]  active_exception_number_i,
    input  wire logic        reg_valid_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_priv_i,
    input  wire logic [31:0] reg_addr_i,
    input  wire logic [3:0]  reg_be_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic             acc_done_o,
    output logic             acc_default_o,
    output logic [4:0]       acc_type_o,
    output logic             acc_share_o,
    output logic [2:0]       access_permission_code_o,
    output logic             execute_never_o,
    output logic             fetch_violation_flag_o,
    output logic             data_violation_flag_o,
    output logic             fault_address_valid_o,
    output logic [31:0]      fault_address_capture_o,
    output logic             memory_management_exception_o,
    output logic [31:0]      reg_rdata_o,
    output logic             reg_ready_o
);
    localparam int NR = rpu_pkg::NUM_REGIONS;

    // register state
    logic [2:0]  protection_control_reg_r;
    logic [7:0]  region_number_select_r;
    logic [31:0] region_base_word_r      [NR];
    logic [31:0] region_attribute_word_r [NR];

    wire en_w    = PRESENT & protection_control_reg_r[rpu_pkg::CTRL_EN_BIT];
    wire hfnmi_w = protection_control_reg_r[rpu_pkg::CTRL_HFNMI_BIT];
    wire priv_bg_w = protection_control_reg_r[rpu_pkg::CTRL_PRIV_BIT];

    // byte-lane merge, little endian
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // per-region hit test
    function automatic logic region_hit(input logic [31:0] addr,
                                        input logic [31:0] base,
                                        input logic [31:0] attr);
        logic [5:0]  lsbit;
        logic [31:0] mask;
        logic [2:0]  sub;
        logic        h;
        lsbit = {1'b0, attr[5:1]} + 6'h01;
        mask  = (lsbit == rpu_pkg::SIZE_FULL) ? 32'h00000000 : (32'hffffffff << lsbit);
        sub   = 3'(addr >> (lsbit - 6'h03));
        h     = attr[rpu_pkg::ATTR_EN_BIT] && ((addr & mask) == (base & mask));
        if (h && lsbit >= rpu_pkg::SIZE_SUBREG) begin
            h = !attr[rpu_pkg::ATTR_SRD_LSB + 32'(sub)];
        end
        return h;
    endfunction : region_hit

    // register address decode
    logic        reg_hit_w;
    logic [2:0]  reg_off_sel_w;
    logic [1:0]  reg_alias_w;
    logic        reg_is_base_w;
    always_comb begin
        reg_hit_w     = 1'b1;
        reg_off_sel_w = 3'h0;
        reg_alias_w   = 2'h0;
        reg_is_base_w = 1'b0;
        case ({reg_addr_i[31:2], 2'h0})
            rpu_pkg::ADDR_TYPE:    reg_off_sel_w = 3'h0;
            rpu_pkg::ADDR_CTRL:    reg_off_sel_w = 3'h1;
            rpu_pkg::ADDR_RNR:     reg_off_sel_w = 3'h2;
            rpu_pkg::ADDR_BASE:    begin
                reg_off_sel_w = 3'h3;
                reg_is_base_w = 1'b1;
            end
            rpu_pkg::ADDR_ATTR:    reg_off_sel_w = 3'h3;
            rpu_pkg::ADDR_BASE_A1: begin
                reg_off_sel_w = 3'h3;
                reg_alias_w   = 2'h1;
                reg_is_base_w = 1'b1;
            end
            rpu_pkg::ADDR_ATTR_A1: begin
                reg_off_sel_w = 3'h3;
                reg_alias_w   = 2'h1;
            end
            rpu_pkg::ADDR_BASE_A2: begin
                reg_off_sel_w = 3'h3;
                reg_alias_w   = 2'h2;
                reg_is_base_w = 1'b1;
            end
            rpu_pkg::ADDR_ATTR_A2: begin
                reg_off_sel_w = 3'h3;
                reg_alias_w   = 2'h2;
            end
            rpu_pkg::ADDR_BASE_A3: begin
                reg_off_sel_w = 3'h3;
                reg_alias_w   = 2'h3;
                reg_is_base_w = 1'b1;
            end
            rpu_pkg::ADDR_ATTR_A3: begin
                reg_off_sel_w = 3'h3;
                reg_alias_w   = 2'h3;
            end
            default:               reg_hit_w = 1'b0;
        endcase
    end

    // selected region index, with alias offset
    // one extra bit so a high region number plus an alias never wraps onto region 0
    wire [8:0] sel_num_w = {1'b0, region_number_select_r} + {7'h00, reg_alias_w};
    wire       sel_ok_w  = PRESENT && (sel_num_w < 9'(rpu_pkg::REGION_COUNT));
    wire [2:0] sel_idx_w = sel_num_w[2:0];

    wire reg_acc_w   = ce_i && reg_valid_i && reg_hit_w;
    wire reg_ok_w    = reg_acc_w && reg_priv_i;
    wire reg_wr_w    = reg_ok_w && reg_write_i;
    // byte-lane merges for control and region number; unwritten lanes keep their value
    wire [31:0] wr_ctrl_w = merge_bytes({29'h0, protection_control_reg_r},
                                        reg_wdata_i, reg_be_i);
    wire [31:0] wr_rnr_w  = merge_bytes({24'h0, region_number_select_r},
                                        reg_wdata_i, reg_be_i);

    // control register, cleared on reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            protection_control_reg_r <= 3'(rpu_pkg::RESET_CTRL);
        end else if (reg_wr_w && PRESENT && reg_off_sel_w == 3'h1) begin
            protection_control_reg_r <= wr_ctrl_w[2:0] & rpu_pkg::CTRL_MASK;
        end
    end

    // region number: direct write or valid base write
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            region_number_select_r <= 8'h00;
        end else if (reg_wr_w && PRESENT && reg_off_sel_w == 3'h2) begin
            region_number_select_r <= wr_rnr_w[7:0];
        end else if (reg_wr_w && PRESENT && reg_is_base_w && reg_alias_w == 2'h0
                     && reg_be_i[0] && reg_wdata_i[rpu_pkg::BASE_VALID_BIT]) begin
            region_number_select_r <= {4'h0, reg_wdata_i[3:0]};
        end
    end

    // region storage; a valid base write targets the named region
    wire [2:0] base_tgt_w = (reg_alias_w == 2'h0 && reg_be_i[0] &&
                             reg_wdata_i[rpu_pkg::BASE_VALID_BIT]) ?
                            reg_wdata_i[2:0] : sel_idx_w;
    wire       base_tgt_ok_w = (reg_alias_w == 2'h0 && reg_be_i[0] &&
                                reg_wdata_i[rpu_pkg::BASE_VALID_BIT]) ?
                               (PRESENT && reg_wdata_i[3:0] < 4'(rpu_pkg::NUM_REGIONS)) :
                               sel_ok_w;
    for (genvar g = 0; g < NR; g++) begin : g_region
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                region_base_word_r[g]      <= 32'h00000000;
                region_attribute_word_r[g] <= 32'h00000000;
            end else if (reg_wr_w && reg_off_sel_w == 3'h3) begin
                if (reg_is_base_w && base_tgt_ok_w && base_tgt_w == 3'(g)) begin
                    region_base_word_r[g] <= merge_bytes(region_base_word_r[g],
                                             reg_wdata_i, reg_be_i) & rpu_pkg::BASE_ADDR_MASK;
                end else if (!reg_is_base_w && sel_ok_w && sel_idx_w == 3'(g)) begin
                    region_attribute_word_r[g] <= merge_bytes(region_attribute_word_r[g],
                                                  reg_wdata_i, reg_be_i);
                end
            end
        end
    end

    // register read data
    logic [31:0] rdata_w;
    always_comb begin
        rdata_w = 32'h00000000;
        case (reg_off_sel_w)
            3'h0: rdata_w = PRESENT ?
                            {16'h0000, rpu_pkg::REGION_COUNT, 8'h00} : 32'h0;
            3'h1: rdata_w = PRESENT ? {29'h0, protection_control_reg_r} : 32'h0;
            3'h2: rdata_w = PRESENT ? {24'h0, region_number_select_r} : 32'h0;
            3'h3: begin
                if (sel_ok_w && reg_is_base_w) begin
                    rdata_w = {region_base_word_r[sel_idx_w][31:5], 1'b0,
                               region_number_select_r[3:0]};
                end else if (sel_ok_w) begin
                    rdata_w = region_attribute_word_r[sel_idx_w];
                end
            end
            default: rdata_w = 32'h00000000;
        endcase
    end

    // register bus answer, one cycle after request
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 32'h00000000;
            reg_ready_o <= 1'b0;
        end else if (ce_i) begin
            reg_ready_o <= reg_valid_i;
            reg_rdata_o <= (reg_ok_w && !reg_write_i) ? rdata_w : 32'h00000000;
        end
    end
    wire reg_fault_w = reg_acc_w && !reg_priv_i;

    // region scan, highest index wins
    logic       found_w;
    logic [2:0] win_w;
    always_comb begin
        found_w = 1'b0;
        win_w   = 3'h0;
        for (int r = 0; r < NR; r++) begin
            if (region_hit(acc_addr_i, region_base_word_r[r], region_attribute_word_r[r])) begin
                found_w = 1'b1;
                win_w   = 3'(r);
            end
        end
    end

    // attribute resolution and permission check
    logic        dflt_w;
    logic [4:0]  type_w;
    logic        share_w;
    logic [2:0]  ap_w;
    logic        xn_w;
    logic        miss_w;
    logic        perm_fault_w;
    logic [15:0] ac_w;
    always_comb begin
        dflt_w  = 1'b1;
        type_w  = rpu_pkg::DEFAULT_TYPE;
        share_w = 1'b0;
        ap_w    = 3'h3;
        xn_w    = 1'b0;
        miss_w  = 1'b0;
        ac_w    = region_attribute_word_r[win_w][31:16];
        if (acc_vector_i || acc_addr_i[31:20] == 12'he00) begin
            dflt_w = 1'b1;
        end else if ((active_exception_number_i == rpu_pkg::EXC_NMI ||
                      active_exception_number_i == rpu_pkg::EXC_HARD_FAULT_EXCEPTION) && !hfnmi_w) begin
            dflt_w = 1'b1;
        end else if (!en_w) begin
            dflt_w = 1'b1;
        end else if (found_w) begin
            dflt_w  = 1'b0;
            type_w  = {ac_w[5:3], ac_w[1:0]};
            share_w = ac_w[2];
            ap_w    = ac_w[10:8];
            xn_w    = ac_w[12];
        end else if (priv_bg_w) begin
            ap_w = rpu_pkg::AP_BACKGROUND;
            xn_w = (acc_addr_i[31:28] > rpu_pkg::XN_TOP_LIMIT) ||
                   (acc_addr_i[31:29] == rpu_pkg::XN_PERIPH_SEG);
        end else begin
            // a miss uses no map at all: it faults instead
            dflt_w = 1'b0;
            miss_w = 1'b1;
        end
        // permission code: 0 none, 1 priv only, 5 priv read only, 2 priv rw user ro,
        // 3 full, 6/7 read only for all
        perm_fault_w = 1'b0;
        case (ap_w)
            3'h0:    perm_fault_w = 1'b1;
            3'h1:    perm_fault_w = !acc_priv_i;
            3'h2:    perm_fault_w = !acc_priv_i && acc_write_i;
            3'h3:    perm_fault_w = 1'b0;
            3'h5:    perm_fault_w = !acc_priv_i || acc_write_i;
            3'h6:    perm_fault_w = acc_write_i;
            3'h7:    perm_fault_w = acc_write_i;
            default: perm_fault_w = 1'b1;
        endcase
        if (acc_fetch_i && xn_w) begin
            perm_fault_w = 1'b1;
        end
        if (miss_w) begin
            perm_fault_w = 1'b0;
        end
    end

    wire viol_w = ce_i && acc_valid_i && (miss_w || perm_fault_w);

    // access result registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_done_o               <= 1'b0;
            acc_default_o            <= 1'b0;
            acc_type_o               <= 5'h00;
            acc_share_o              <= 1'b0;
            access_permission_code_o <= 3'h0;
            execute_never_o          <= 1'b0;
        end else if (ce_i) begin
            acc_done_o <= acc_valid_i;
            if (acc_valid_i) begin
                acc_default_o            <= dflt_w;
                acc_type_o               <= type_w;
                acc_share_o              <= share_w;
                access_permission_code_o <= ap_w;
                execute_never_o          <= xn_w;
            end
        end
    end

    // fault status flags and exception pulse
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_violation_flag_o        <= 1'b0;
            data_violation_flag_o         <= 1'b0;
            fault_address_valid_o         <= 1'b0;
            fault_address_capture_o       <= 32'h00000000;
            memory_management_exception_o <= 1'b0;
        end else if (ce_i) begin
            memory_management_exception_o <= viol_w || reg_fault_w;
            if (viol_w && acc_fetch_i) begin
                fetch_violation_flag_o <= 1'b1;
                fault_address_valid_o  <= 1'b0;
            end else if (viol_w) begin
                data_violation_flag_o   <= 1'b1;
                fault_address_capture_o <= acc_addr_i;
                fault_address_valid_o   <= 1'b1;
            end else if (reg_fault_w) begin
                data_violation_flag_o   <= 1'b1;
                fault_address_capture_o <= reg_addr_i;
                fault_address_valid_o   <= 1'b1;
            end
        end
    end
endmodule : rpu_top

`default_nettype wire

// >>> test/rpu_top_sva.sv
// port assertions for the region protection unit
`timescale 1ns/1ps
`default_nettype none
module rpu_top_sva (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        ce_i,
    input wire logic        acc_valid_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic        acc_fetch_i,
    input wire logic        acc_vector_i,
    input wire logic        reg_valid_i,
    input wire logic        acc_done_o,
    input wire logic        acc_default_o,
    input wire logic        fetch_violation_flag_o,
    input wire logic        data_violation_flag_o,
    input wire logic        fault_address_valid_o,
    input wire logic [31:0] fault_address_capture_o,
    input wire logic        memory_management_exception_o,
    input wire logic        reg_ready_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // an accepted access and a data access that then faults
    sequence s_acc;
        ce_i && acc_valid_i;
    endsequence
    sequence s_data_fault;
        ce_i && acc_valid_i && !acc_fetch_i && !acc_vector_i && !reg_valid_i
            ##1 memory_management_exception_o;
    endsequence
    property p_done; s_acc |=> acc_done_o; endproperty
    property p_idle; ce_i && !acc_valid_i |=> !acc_done_o; endproperty
    property p_ready; ce_i && reg_valid_i |=> reg_ready_o; endproperty
    property p_exc_src; memory_management_exception_o |-> acc_done_o || reg_ready_o; endproperty
    property p_bypass;
        ce_i && acc_valid_i && (acc_vector_i || acc_addr_i[31:20] == 12'he00) |=> acc_default_o;
    endproperty
    property p_fetch;
        ce_i && acc_valid_i && acc_fetch_i && !acc_vector_i && !reg_valid_i
            ##1 memory_management_exception_o
            |-> fetch_violation_flag_o;
    endproperty
    property p_data;
        s_data_fault |-> data_violation_flag_o && fault_address_valid_o
            && fault_address_capture_o == $past(acc_addr_i);
    endproperty
    property p_sticky; !$fell(fetch_violation_flag_o) && !$fell(data_violation_flag_o); endproperty
    a_done: assert property (p_done) else $error("access not answered");
    a_idle: assert property (p_idle) else $error("done without access");
    a_ready: assert property (p_ready) else $error("register access not answered");
    a_exc_src: assert property (p_exc_src) else $error("exception without cause");
    a_bypass: assert property (p_bypass) else $error("bypass not default");
    a_fetch: assert property (p_fetch) else $error("fetch fault flag missing");
    a_data: assert property (p_data) else $error("data fault capture wrong");
    a_sticky: assert property (p_sticky) else $error("violation flag dropped");
endmodule : rpu_top_sva
`default_nettype wire

// >>> test/rpu_core_model.sv
// behavioural core access path facing the protection unit
`timescale 1ns/1ps
`default_nettype none
module rpu_core_model (
    input  wire logic        clk_i,
    output logic             valid_o,
    output logic [31:0]      addr_o,
    output logic [3:0]       kind_o,
    output logic [8:0]       exc_o
);
    // kind_o is {write, privileged, fetch, vector}
    initial begin
        valid_o = 1'b0;
        addr_o = 32'h0;
        kind_o = 4'h0;
        exc_o = 9'h000;
    end
    // drive after a falling edge, hold across the taking edge, then scramble
    task automatic access(input logic [31:0] a, input logic [3:0] k);
        @(negedge clk_i);
        addr_o = a;
        kind_o = k;
        valid_o = 1'b1;
        @(negedge clk_i);
        valid_o = 1'b0;
        addr_o = ~a;
        kind_o = ~k;
    endtask : access
endmodule : rpu_core_model
`default_nettype wire

// >>> test/rpu_top_test.sv
// self-checking bench for the region protection unit
`timescale 1ns/1ps
`default_nettype none
module rpu_top_test;
    logic        clk_i, rstn_i, ce_i, reg_valid_i, reg_write_i, reg_priv_i;
    logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, acc_addr_i, fault_address_capture_o;
    logic [3:0]  reg_be_i;
    logic [8:0]  active_exception_number_i;
    logic [2:0]  access_permission_code_o;
    logic [4:0]  acc_type_o;
    logic        acc_valid_i, acc_write_i, acc_priv_i, acc_fetch_i, acc_vector_i, acc_done_o;
    logic        acc_default_o, acc_share_o, execute_never_o, fetch_violation_flag_o;
    logic        data_violation_flag_o, fault_address_valid_o, memory_management_exception_o;
    logic        reg_ready_o;
    logic [31:0] absent_rdata;
    int          mismatches, compares;
    logic [31:0] bg_addr [4] = '{32'h40000000, 32'h60000000, 32'ha0000000, 32'h90000000};
    logic        bg_xn [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    rpu_core_model core (.clk_i(clk_i), .valid_o(acc_valid_i), .addr_o(acc_addr_i),
        .kind_o({acc_write_i, acc_priv_i, acc_fetch_i, acc_vector_i}),
        .exc_o(active_exception_number_i));
    rpu_top DUT (.clk_i, .rstn_i, .ce_i, .acc_valid_i, .acc_addr_i, .acc_write_i, .acc_priv_i,
        .acc_fetch_i, .acc_vector_i, .active_exception_number_i, .reg_valid_i, .reg_write_i,
        .reg_priv_i, .reg_addr_i, .reg_be_i, .reg_wdata_i, .acc_done_o, .acc_default_o,
        .acc_type_o, .acc_share_o, .access_permission_code_o, .execute_never_o,
        .fetch_violation_flag_o, .data_violation_flag_o, .fault_address_valid_o,
        .fault_address_capture_o, .memory_management_exception_o, .reg_rdata_o, .reg_ready_o);
    // a unit built without protection, sharing every input; only its read data is watched
    rpu_top #(.PRESENT(1'b0)) ABSENT (.clk_i, .rstn_i, .ce_i, .acc_valid_i, .acc_addr_i,
        .acc_write_i, .acc_priv_i, .acc_fetch_i, .acc_vector_i, .active_exception_number_i,
        .reg_valid_i, .reg_write_i, .reg_priv_i, .reg_addr_i, .reg_be_i, .reg_wdata_i,
        .acc_done_o(), .acc_default_o(), .acc_type_o(), .acc_share_o(),
        .access_permission_code_o(), .execute_never_o(), .fetch_violation_flag_o(),
        .data_violation_flag_o(), .fault_address_valid_o(), .fault_address_capture_o(),
        .memory_management_exception_o(), .reg_rdata_o(absent_rdata), .reg_ready_o());
    // report and stop
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // compare a register or status value
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t value %h expected %h", $time, g, e);
        end
    endtask : chk_reg
    // compare done, default-map use and exception of the last access
    task automatic chk_acc(input logic d, input logic e);
        compares++;
        if ({acc_done_o, acc_default_o, memory_management_exception_o} !== {1'b1, d, e}) begin
            mismatches++;
            $display("ERROR %0t access result default %b exc %b", $time, acc_default_o,
                memory_management_exception_o);
        end
    endtask : chk_acc
    // one register transfer, answered one cycle later
    task automatic rw(input logic w, input logic p, input logic [31:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(negedge clk_i);
        {reg_write_i, reg_priv_i, reg_addr_i, reg_be_i, reg_wdata_i} = {w, p, a, be, d};
        reg_valid_i = 1'b1;
        @(negedge clk_i);
        reg_valid_i = 1'b0;
        chk_reg({31'h0, reg_ready_o}, 32'h1);
    endtask : rw
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        rw(1'b1, 1'b1, a, 4'hf, d);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rw(1'b0, 1'b1, a, 4'hf, 32'h0);
        chk_reg(reg_rdata_o, e);
    endtask : rd
    task automatic acc(input logic [31:0] a, input logic [3:0] k, input logic d, input logic e);
        core.access(a, k);
        chk_acc(d, e);
    endtask : acc
    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // watchdog
    initial begin
        #(40 * 3000);
        mismatches++;
        give_verdict();
    end
    // main sequence
    initial begin
        {rstn_i, reg_valid_i, reg_write_i, reg_priv_i, reg_be_i} = '0;
        {reg_addr_i, reg_wdata_i} = '0;
        ce_i = 1'b1;
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        rd(rpu_pkg::ADDR_TYPE, 32'h00000800);
        chk_reg(absent_rdata, 32'h0);
        rd(rpu_pkg::ADDR_CTRL, 32'h0);
        rd(32'he000edc0, 32'h0);
        wr(rpu_pkg::ADDR_BASE, 32'h20000011);
        rd(rpu_pkg::ADDR_RNR, 32'h1);
        rd(rpu_pkg::ADDR_BASE, 32'h20000001);
        rw(1'b1, 1'b1, rpu_pkg::ADDR_ATTR, 4'h3, 32'h0000021f);
        rw(1'b1, 1'b1, rpu_pkg::ADDR_ATTR, 4'hc, 32'h030d0000);
        rd(rpu_pkg::ADDR_ATTR, 32'h030d021f);
        wr(rpu_pkg::ADDR_BASE_A1, 32'h20000000);
        wr(rpu_pkg::ADDR_ATTR_A1, 32'h16000009);
        wr(rpu_pkg::ADDR_CTRL, 32'h1);
        acc(32'h20000004, 4'b0000, 1'b0, 1'b0);
        chk_reg({access_permission_code_o, execute_never_o}, 4'hd);
        acc(32'h20000004, 4'b1000, 1'b0, 1'b1);
        chk_reg(fault_address_capture_o, 32'h20000004);
        acc(32'h20000100, 4'b0000, 1'b0, 1'b0);
        chk_reg({acc_type_o, acc_share_o, access_permission_code_o, execute_never_o}, 10'h0b6);
        acc(32'h20002000, 4'b0100, 1'b0, 1'b1);
        chk_reg({fetch_violation_flag_o, data_violation_flag_o, fault_address_valid_o}, 3'h3);
        acc(32'h20010000, 4'b0110, 1'b0, 1'b1);
        chk_reg({fetch_violation_flag_o, data_violation_flag_o, fault_address_valid_o}, 3'h6);
        acc(32'h20010000, 4'b0101, 1'b1, 1'b0);
        acc(32'he000e010, 4'b0100, 1'b1, 1'b0);
        core.exc_o = rpu_pkg::EXC_HARD_FAULT_EXCEPTION;
        acc(32'h30000000, 4'b0000, 1'b1, 1'b0);
        core.exc_o = rpu_pkg::EXC_NMI;
        acc(32'h30000000, 4'b0000, 1'b1, 1'b0);
        wr(rpu_pkg::ADDR_CTRL, 32'h3);
        acc(32'h30000000, 4'b0100, 1'b0, 1'b1);
        core.exc_o = 9'h000;
        wr(rpu_pkg::ADDR_CTRL, 32'h5);
        for (int i = 0; i < 4; i++) begin
            acc(bg_addr[i], 4'b0100, 1'b1, 1'b0);
            chk_reg({access_permission_code_o, execute_never_o}, {3'b001, bg_xn[i]});
        end
        wr(rpu_pkg::ADDR_CTRL, 32'h4);
        acc(32'h30000000, 4'b0000, 1'b1, 1'b0);
        rw(1'b1, 1'b0, rpu_pkg::ADDR_CTRL, 4'hf, 32'h1);
        chk_reg({31'h0, memory_management_exception_o}, 32'h1);
        rd(rpu_pkg::ADDR_CTRL, 32'h4);
        chk_reg(absent_rdata, 32'h0);
        wr(rpu_pkg::ADDR_RNR, 32'h1);
        for (int k = 1; k < 4; k++) wr(rpu_pkg::ADDR_ATTR + 32'(8 * k), 32'(k * 256));
        for (int k = 1; k < 4; k++) begin
            wr(rpu_pkg::ADDR_RNR, 32'(1 + k));
            rd(rpu_pkg::ADDR_ATTR, 32'(k * 256));
            chk_reg(absent_rdata, 32'h0);
        end
        give_verdict();
    end
endmodule : rpu_top_test
bind rpu_top rpu_top_sva CHK (.clk_i, .rstn_i, .ce_i, .acc_valid_i, .acc_addr_i, .acc_fetch_i,
    .acc_vector_i, .reg_valid_i, .acc_done_o, .acc_default_o, .fetch_violation_flag_o,
    .data_violation_flag_o, .fault_address_valid_o, .fault_address_capture_o,
    .memory_management_exception_o, .reg_ready_o);
`default_nettype wire
